// ===== logic/adcic_pkg.sv
package adcic_pkg;
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          CONV_50_US      = 160300;
    localparam int          CONV_60_US      = 133600;
    localparam int          CONV_BOTH_US    = 146900;
    localparam int          CONV_50_CYC     = CONV_50_US * 1000 / CLK_PERIOD_NS;
    localparam int          CONV_60_CYC     = CONV_60_US * 1000 / CLK_PERIOD_NS;
    localparam int          CONV_BOTH_CYC   = CONV_BOTH_US * 1000 / CLK_PERIOD_NS;
    localparam int          EXT_MIN_FREQ_HZ = 10000;
    localparam int          EXT_IDLE_CYC    = 1000000000 / EXT_MIN_FREQ_HZ / CLK_PERIOD_NS;
    localparam int          EXT_NULL_DIV    = 5120;
    localparam logic [7:0]  CFG_RESET       = 8'h00;
    localparam int          CFG_TEMP_BIT    = 3;
    localparam int          CFG_REJ_HI_BIT  = 2;
    localparam int          CFG_REJ_LO_BIT  = 1;
    localparam int          CFG_SPD_BIT     = 0;
    localparam logic [1:0]  REJ_BOTH        = 2'h0;
    localparam logic [1:0]  REJ_50          = 2'h1;
    localparam logic [1:0]  REJ_60          = 2'h2;
    localparam logic [3:0]  ADDR_BASE       = 4'h2;
    localparam int          RESULT_BITS     = 32;
    localparam int          READ_BYTES      = 4;
    localparam int          FIFO_DEPTH      = 16;

    typedef enum logic [1:0] {
        ADCIC_CONV  = 2'b00,
        ADCIC_SLEEP = 2'b01,
        ADCIC_IO    = 2'b11
    } adcic_phase_e;

    typedef enum logic [2:0] {
        ADCIC_IDLE   = 3'b000,
        ADCIC_ADDR   = 3'b001,
        ADCIC_ACK_A  = 3'b011,
        ADCIC_RD     = 3'b010,
        ADCIC_RD_ACK = 3'b110,
        ADCIC_WR     = 3'b111,
        ADCIC_WR_ACK = 3'b101,
        ADCIC_SKIP   = 3'b100
    } adcic_ser_e;
endpackage

// ===== logic/adcic_top.sv
`timescale 1ns/1ps
module adcic_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("fifo depth must be a power of two");
        end
    end
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wp_ff;
    logic [AW-1:0]    rp_ff;
    logic [AW:0]      cnt_ff;
    logic [AW:0]      nxt_cnt;
    logic             push;
    logic             pop;
    logic             full_ff;
    logic             empty_ff;

    assign push      = in_valid && !full_ff;
    assign pop       = out_ready && !empty_ff;
    assign in_ready  = !full_ff;
    assign out_valid = !empty_ff;
    assign out_data  = mem_ff[rp_ff];
    assign nxt_cnt   = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_ff[wp_ff] <= in_data;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wp_ff    <= '0;
            rp_ff    <= '0;
            cnt_ff   <= '0;
            full_ff  <= 1'b0;
            empty_ff <= 1'b1;
        end else begin
            wp_ff    <= wp_ff + AW'(push);
            rp_ff    <= rp_ff + AW'(pop);
            cnt_ff   <= nxt_cnt;
            full_ff  <= (nxt_cnt == (AW+1)'(DEPTH));
            empty_ff <= (nxt_cnt == '0);
        end
    end
endmodule // adcic_fifo

module adcic_top #(
    parameter int CONV_50_CYC   = adcic_pkg::CONV_50_CYC,
    parameter int CONV_60_CYC   = adcic_pkg::CONV_60_CYC,
    parameter int CONV_BOTH_CYC = adcic_pkg::CONV_BOTH_CYC,
    parameter int EXT_IDLE_CYC  = adcic_pkg::EXT_IDLE_CYC,
    parameter int FIFO_DEPTH    = adcic_pkg::FIFO_DEPTH
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    input  wire logic        address_pin_tristate_hi,
    input  wire logic        address_pin_tristate_float,
    input  wire logic        address_pin_or_ext_clock,
    input  wire logic        result_valid,
    output logic             result_ready,
    input  wire logic [31:0] result_data,
    output logic             converting,
    output logic             temperature_input_select,
    output logic [1:0]       rejection_mode,
    output logic             double_rate_select,
    output logic             ext_clock_active
);
    initial begin
        if (CONV_50_CYC < 2 || CONV_60_CYC < 2 || CONV_BOTH_CYC < 2 || EXT_IDLE_CYC < 2) begin
            $error("cycle counts too small");
        end
    end

    logic [4:0] pin_s1_ff;
    logic [4:0] pin_s2_ff;
    logic       scl_d_ff;
    logic       sda_d_ff;
    logic       ca0_d_ff;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_ff <= 5'h13;
            pin_s2_ff <= 5'h13;
            scl_d_ff  <= 1'b1;
            sda_d_ff  <= 1'b1;
            ca0_d_ff  <= 1'b1;
        end else begin
            pin_s1_ff <= {address_pin_or_ext_clock, address_pin_tristate_float,
                          address_pin_tristate_hi, sda_i, scl_i};
            pin_s2_ff <= pin_s1_ff;
            scl_d_ff  <= pin_s2_ff[0];
            sda_d_ff  <= pin_s2_ff[1];
            ca0_d_ff  <= pin_s2_ff[4];
        end
    end
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    assign scl_s    = pin_s2_ff[0];
    assign sda_s    = pin_s2_ff[1];
    assign scl_rise = scl_s && !scl_d_ff;
    assign scl_fall = !scl_s && scl_d_ff;
    assign start_ev = scl_s && scl_d_ff && !sda_s && sda_d_ff;
    assign stop_ev  = scl_s && scl_d_ff && sda_s && !sda_d_ff;

    logic [31:0] ext_idle_ff;
    logic        ext_act_ff;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ext_idle_ff <= '0;
            ext_act_ff  <= 1'b0;
        end else if (pin_s2_ff[4] != ca0_d_ff) begin
            ext_idle_ff <= '0;
            ext_act_ff  <= 1'b1;
        end else if (ext_idle_ff < 32'(EXT_IDLE_CYC)) begin
            ext_idle_ff <= ext_idle_ff + 32'h1;
        end else begin
            ext_act_ff  <= 1'b0;
        end
    end

    logic [6:0] own_addr;
    logic [1:0] ca1_code;
    assign ca1_code = pin_s2_ff[3] ? 2'h2 : (pin_s2_ff[2] ? 2'h1 : 2'h0);
    assign own_addr = {adcic_pkg::ADDR_BASE, ca1_code, ext_act_ff | pin_s2_ff[4]};

    // conversion result buffer
    logic        fifo_pop;
    logic        fifo_valid;
    logic [31:0] fifo_data;
    adcic_fifo #(
        .WIDTH (adcic_pkg::RESULT_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_valid  (result_valid),
        .in_ready  (result_ready),
        .in_data   (result_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    adcic_pkg::adcic_phase_e phase_ff;
    adcic_pkg::adcic_ser_e   ser_ff;
    logic [7:0]  cfg_ff;
    logic [7:0]  cfg_pend_ff;
    logic        wr_valid_ff;
    logic [31:0] result_ff;
    logic [31:0] tx_ff;
    logic [7:0]  rx_ff;
    logic [3:0]  bit_ff;
    logic [1:0]  byte_ff;
    logic        is_read_ff;
    logic        rd_done_ff;
    logic        sda_oe_ff;
    logic [31:0] timer_ff;
    logic [31:0] conv_target;
    logic        addr_hit;
    logic        do_ack;

    assign addr_hit = (rx_ff[7:1] == own_addr);
    // no second read after full read
    assign do_ack   = addr_hit && (phase_ff != adcic_pkg::ADCIC_CONV) && !(rx_ff[0] && rd_done_ff);

    always_comb begin
        case (cfg_ff[adcic_pkg::CFG_REJ_HI_BIT:adcic_pkg::CFG_REJ_LO_BIT])
            adcic_pkg::REJ_50: conv_target = 32'(CONV_50_CYC);
            adcic_pkg::REJ_60: conv_target = 32'(CONV_60_CYC);
            default:           conv_target = 32'(CONV_BOTH_CYC);
        endcase
        if (cfg_ff[adcic_pkg::CFG_SPD_BIT] && !cfg_ff[adcic_pkg::CFG_TEMP_BIT]) begin
            conv_target = conv_target >> 1;
        end
    end

    assign fifo_pop = (phase_ff == adcic_pkg::ADCIC_CONV) && (timer_ff >= conv_target) && fifo_valid;

    logic rd_complete;
    logic wr_commit;
    assign rd_complete = (ser_ff == adcic_pkg::ADCIC_RD_ACK) && scl_rise && (byte_ff == 2'h3);
    assign wr_commit   = stop_ev && wr_valid_ff;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            phase_ff <= adcic_pkg::ADCIC_CONV;
            timer_ff <= '0;
        end else if (rd_complete || wr_commit) begin
            phase_ff <= adcic_pkg::ADCIC_CONV;
            timer_ff <= '0;
        end else if (phase_ff == adcic_pkg::ADCIC_CONV) begin
            if (fifo_pop) begin
                phase_ff <= adcic_pkg::ADCIC_SLEEP;
            end else if (timer_ff < conv_target) begin
                timer_ff <= timer_ff + 32'h1;
            end
        end else if (ser_ff == adcic_pkg::ADCIC_ACK_A && scl_fall && sda_oe_ff) begin
            phase_ff <= adcic_pkg::ADCIC_IO;
        end else if (stop_ev) begin
            phase_ff <= adcic_pkg::ADCIC_SLEEP;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            result_ff <= '0;
        end else if (fifo_pop) begin
            result_ff <= fifo_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ff <= adcic_pkg::CFG_RESET;
        end else if (wr_commit) begin
            cfg_ff <= cfg_pend_ff;
        end
    end

    // serial engine
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ser_ff      <= adcic_pkg::ADCIC_IDLE;
            rx_ff       <= '0;
            tx_ff       <= '0;
            bit_ff      <= '0;
            byte_ff     <= '0;
            is_read_ff  <= 1'b0;
            sda_oe_ff   <= 1'b0;
            wr_valid_ff <= 1'b0;
            cfg_pend_ff <= adcic_pkg::CFG_RESET;
            rd_done_ff  <= 1'b0;
        end else if (start_ev) begin
            ser_ff    <= adcic_pkg::ADCIC_ADDR;
            bit_ff    <= '0;
            sda_oe_ff <= 1'b0;
        end else if (stop_ev) begin
            ser_ff      <= adcic_pkg::ADCIC_IDLE;
            sda_oe_ff   <= 1'b0;
            wr_valid_ff <= 1'b0;
            rd_done_ff  <= 1'b0;
        end else begin
            case (ser_ff)
                adcic_pkg::ADCIC_ADDR, adcic_pkg::ADCIC_WR: begin
                    if (scl_rise) begin
                        rx_ff  <= {rx_ff[6:0], sda_s};
                        bit_ff <= bit_ff + 4'h1;
                    end else if (scl_fall && bit_ff == 4'h8) begin
                        if (ser_ff == adcic_pkg::ADCIC_WR) begin
                            ser_ff      <= adcic_pkg::ADCIC_WR_ACK;
                            sda_oe_ff   <= 1'b1;
                            cfg_pend_ff <= rx_ff;
                            wr_valid_ff <= 1'b1;
                        end else begin
                            ser_ff     <= do_ack ? adcic_pkg::ADCIC_ACK_A : adcic_pkg::ADCIC_SKIP;
                            sda_oe_ff  <= do_ack;
                            is_read_ff <= rx_ff[0];
                            tx_ff      <= result_ff;
                            byte_ff    <= '0;
                        end
                    end
                end
                adcic_pkg::ADCIC_ACK_A: begin
                    if (scl_fall) begin
                        bit_ff <= '0;
                        if (is_read_ff) begin
                            ser_ff    <= adcic_pkg::ADCIC_RD;
                            sda_oe_ff <= !tx_ff[31];
                            tx_ff     <= {tx_ff[30:0], 1'b0};
                        end else begin
                            ser_ff    <= adcic_pkg::ADCIC_WR;
                            sda_oe_ff <= 1'b0;
                        end
                    end
                end
                adcic_pkg::ADCIC_RD: begin
                    if (scl_rise) begin
                        bit_ff <= bit_ff + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_ff == 4'h8) begin
                            ser_ff    <= adcic_pkg::ADCIC_RD_ACK;
                            sda_oe_ff <= 1'b0;
                        end else begin
                            sda_oe_ff <= !tx_ff[31];
                            tx_ff     <= {tx_ff[30:0], 1'b0};
                        end
                    end
                end
                adcic_pkg::ADCIC_RD_ACK: begin
                    if (scl_rise) begin
                        if (byte_ff == 2'h3) begin
                            ser_ff     <= adcic_pkg::ADCIC_SKIP;
                            rd_done_ff <= 1'b1;
                            tx_ff      <= '0;
                        end else if (sda_s) begin
                            ser_ff <= adcic_pkg::ADCIC_SKIP;
                        end
                        byte_ff <= byte_ff + 2'h1;
                    end else if (scl_fall) begin
                        ser_ff    <= adcic_pkg::ADCIC_RD;
                        bit_ff    <= '0;
                        sda_oe_ff <= !tx_ff[31];
                        tx_ff     <= {tx_ff[30:0], 1'b0};
                    end
                end
                adcic_pkg::ADCIC_WR_ACK: begin
                    if (scl_fall) begin
                        ser_ff    <= adcic_pkg::ADCIC_SKIP;
                        sda_oe_ff <= 1'b0;
                    end
                end
                default: begin
                    sda_oe_ff <= 1'b0;
                end
            endcase
        end
    end

    assign sda_o                    = 1'b0;
    assign sda_oe                   = sda_oe_ff;
    assign converting               = (phase_ff == adcic_pkg::ADCIC_CONV);
    assign temperature_input_select = cfg_ff[adcic_pkg::CFG_TEMP_BIT];
    assign rejection_mode           = cfg_ff[adcic_pkg::CFG_REJ_HI_BIT:adcic_pkg::CFG_REJ_LO_BIT];
    assign double_rate_select       = cfg_ff[adcic_pkg::CFG_SPD_BIT] && !cfg_ff[adcic_pkg::CFG_TEMP_BIT];
    assign ext_clock_active         = ext_act_ff;

    a_conv_nak: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ser_ff == adcic_pkg::ADCIC_ADDR && scl_fall && bit_ff == 4'h8 && converting)
        |=> !sda_oe_ff) else $error("acknowledged while converting");
    a_sleep_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (phase_ff == adcic_pkg::ADCIC_SLEEP) |=> $stable(result_ff)) else $error("result changed in sleep");
    a_conv_to_sleep: assert property (@(posedge clk_sys) disable iff (!rst_n)
        fifo_pop |=> (phase_ff == adcic_pkg::ADCIC_SLEEP)) else $error("no sleep after conversion");
    a_read_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rd_complete |=> converting && timer_ff == 32'h0 && rd_done_ff) else $error("no restart after read");
    a_write_apply: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_commit |=> converting && cfg_ff == $past(cfg_pend_ff)) else $error("config not applied");
    a_cfg_stable: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !wr_commit |=> $stable(cfg_ff)) else $error("config changed without write");
    a_oe_when_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ($changed(sda_oe_ff) && !$past(start_ev) && !$past(stop_ev)) |-> !scl_d_ff) else $error("oe with scl high");
    a_stop_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
        stop_ev |=> !sda_oe_ff && ser_ff == adcic_pkg::ADCIC_IDLE) else $error("stop not honoured");
    a_start_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
        start_ev |=> ser_ff == adcic_pkg::ADCIC_ADDR && bit_ff == 4'h0) else $error("start not honoured");
    a_temp_speed: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (temperature_input_select && rejection_mode == adcic_pkg::REJ_BOTH)
        |-> conv_target == 32'(CONV_BOTH_CYC)) else $error("double rate with temperature input");
    a_no_reread: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (rd_done_ff && ser_ff == adcic_pkg::ADCIC_ADDR && scl_fall && bit_ff == 4'h8 && rx_ff[0])
        |=> !sda_oe_ff) else $error("second read acknowledged");
    a_ext_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ext_act_ff |-> own_addr[0]) else $error("address bit not forced high");
endmodule // adcic_top

// ===== testbench/adcic_master.sv
`timescale 1ns/1ps
module adcic_master #(
    parameter int QTR = 63
) (
    input  wire logic clk_sys,
    input  wire logic sda,
    output logic      scl,
    output logic      pull
);
    initial begin
        scl  = 1'b1;
        pull = 1'b0;
    end
    task automatic wait_q();
        repeat (QTR) @(negedge clk_sys);
    endtask
    // bit below 400k, data moves while scl low
    task automatic bit_io(input logic b, output logic r);
        pull = ~b;
        wait_q();
        scl = 1'b1;
        wait_q();
        r = sda;
        wait_q();
        scl = 1'b0;
        wait_q();
    endtask
    task automatic start();
        pull = 1'b0;
        wait_q();
        scl = 1'b1;
        wait_q();
        pull = 1'b1;
        wait_q();
        scl = 1'b0;
        wait_q();
    endtask
    task automatic stop();
        pull = 1'b1;
        wait_q();
        scl = 1'b1;
        wait_q();
        pull = 1'b0;
        wait_q();
    endtask
    // eight bits then released ack slot
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic rbyte(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(1'b0, r);
    endtask
endmodule // adcic_master

// ===== testbench/adcic_top_test.sv
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; $display("[FAIL] %0t got %h want %h", $time, a, e); end end
module adcic_top_test;
    localparam logic [6:0]  DEV_ADR = {adcic_pkg::ADDR_BASE, 2'h0, 1'b1};
    localparam logic [31:0] W_BASE  = 32'h9C5A3E10;
    logic        clk_sys, rst_n, scl, pull, sda, sda_o, sda_oe, rv, rr, conv, tsel, dr, extc;
    logic [31:0] rd;
    logic [1:0]  rej;
    logic        ca1_hi, ca1_fl, ca0;
    int          bad_count, check_count;
    assign sda = ~((sda_oe & ~sda_o) | pull);
    adcic_top #(.CONV_50_CYC(3000), .CONV_60_CYC(3000), .CONV_BOTH_CYC(3000), .EXT_IDLE_CYC(50)) i_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .address_pin_tristate_hi(ca1_hi), .address_pin_tristate_float(ca1_fl), .address_pin_or_ext_clock(ca0),
        .result_valid(rv), .result_ready(rr), .result_data(rd), .converting(conv),
        .temperature_input_select(tsel), .rejection_mode(rej), .double_rate_select(dr), .ext_clock_active(extc));
    adcic_master i_master (.clk_sys(clk_sys), .sda(sda), .scl(scl), .pull(pull));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic results();
        if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wait_sleep();
        int n;
        n = 0;
        while (conv !== 1'b0 && n < 8000) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 8000) begin
            bad_count++;
            $display("[FAIL] %0t conversion never ended", $time);
            results();
        end
    endtask
    task automatic t_reset();
        `CHK({tsel, rej, dr}, 4'h0)
        `CHK({conv, sda_oe, extc}, 3'h4)
    endtask
    task automatic t_fill();
        int n;
        n = 0;
        rv = 1'b1;
        while (rr === 1'b1 && n < 20) begin
            rd = W_BASE + n;
            @(negedge clk_sys);
            n++;
        end
        rv = 1'b0;
        `CHK(n, 16)
    endtask
    task automatic t_nak(input logic [6:0] adr, input logic wait_first);
        logic ack;
        if (wait_first) wait_sleep();
        i_master.start();
        i_master.wbyte({adr, 1'b1}, ack);
        i_master.stop();
        `CHK(ack, 1'b0)
    endtask
    task automatic t_read(input int k);
        logic [7:0]  b;
        logic [31:0] w;
        logic        ack;
        wait_sleep();
        repeat (500) @(negedge clk_sys);
        i_master.start();
        i_master.wbyte({DEV_ADR, 1'b1}, ack);
        `CHK(ack, 1'b1)
        for (int i = 0; i < 4; i++) begin
            i_master.rbyte(b);
            w = {w[23:0], b};
        end
        `CHK(w, W_BASE + k)
        `CHK(conv, 1'b1)
        // let the conversion end so only the spent read refuses
        wait_sleep();
        i_master.start();
        i_master.wbyte({DEV_ADR, 1'b1}, ack);
        i_master.stop();
        `CHK(ack, 1'b0)
    endtask
    task automatic t_write(input logic [7:0] cfg, input logic [3:0] want);
        logic [3:0] old;
        logic       ack;
        wait_sleep();
        old = {tsel, rej, dr};
        i_master.start();
        i_master.wbyte({DEV_ADR, 1'b0}, ack);
        `CHK(ack, 1'b1)
        i_master.wbyte(cfg, ack);
        `CHK(ack, 1'b1)
        i_master.wbyte(8'h00, ack);
        `CHK(ack, 1'b0)
        `CHK({tsel, rej, dr}, old)
        i_master.stop();
        repeat (4) @(negedge clk_sys);
        `CHK({tsel, rej, dr}, want)
        `CHK(conv, 1'b1)
    endtask
    task automatic t_pins();
        logic ack;
        for (int i = 0; i < 20; i++) begin
            ca0 = ~ca0;
            repeat (20) @(negedge clk_sys);
        end
        `CHK(extc, 1'b1)
        ca0 = 1'b0;
        ca1_fl = 1'b1;
        repeat (80) @(negedge clk_sys);
        `CHK(extc, 1'b0)
        t_nak(DEV_ADR, 1'b1);
        i_master.start();
        i_master.wbyte({adcic_pkg::ADDR_BASE, 2'h2, 1'b0, 1'b0}, ack);
        i_master.stop();
        `CHK(ack, 1'b1)
    endtask
    initial begin
        rst_n = 1'b0;
        ca1_hi = 1'b0;
        ca1_fl = 1'b0;
        ca0 = 1'b1;
        rv = 1'b0;
        rd = 32'h00000000;
        bad_count = 0;
        check_count = 0;
        repeat (20) @(negedge clk_sys);
        t_reset();
        rst_n = 1'b1;
        @(negedge clk_sys);
        t_fill();
        t_nak(DEV_ADR, 1'b0);
        t_nak(7'h13, 1'b1);
        t_read(0);
        t_write(8'h03, 4'h3);
        t_write(8'h09, 4'h8);
        t_write(8'h04, 4'h4);
        t_read(4);
        `CHK(extc, 1'b0)
        t_pins();
        results();
    end
endmodule // adcic_top_test
